//--- core/i2se_slave_engine.v
// Slave engine of a two-wire serial port: 7/10-bit addressing,
// slave transmit/receive, receive buffer, flags, clock stretching.
// Assumes the CPU side is on core_clk; both bus lines are async pins.
//
// Behaviour
// R1: read address match acks, then holds clock low until transmit write
// R2: transmit shifts 8 bits, data changed on falling clock edges
// R3: transmit interrupt pulse on ninth falling edge regardless of ack
// R4: master ack latched on ninth clock; nack ends transmit, back to idle
// R5: after acked byte clock held until release bit; software loads first
// R6: transmit full sets on CPU write, clears after 8 bits shifted
// R7: write while transmit full sets sticky write collision flag
// R8: read-direction flag holds direction bit of last address match
// R9: write address match enters receive, bits sampled on rising edge
// R10: after 8 bits, buffer not full and no overflow: load buffer and acknowledge
// R11: buffer full at byte end: nack, buffer kept, interrupt still given
// R12: overflow set but buffer empty: load buffer, answer nack
// R13: buffer full sets on data load, not on address; clears on CPU read
// R14: overflow sets when byte arrives while buffer still full
// R15: data-or-address flag shows kind of last received byte
// R16: ten-bit first byte compared with 11110 and top bits, write only
// R17: ten-bit second byte compared with low eight bits, sets match flag
// R18: after full ten-bit match, repeated start high byte read transmits
// R19: transmit ack with empty buffer at ninth fall clears release, stretch
// R20: buffer loaded before ninth fall: no stretch; release settable whatever the buffer state
// R21: stretch enabled receive, buffer full at ninth fall: clear release
// R22: buffer read before ninth fall leaves release set, no stretch
// R23: seven-bit mode compares address low 7 bits with shift bits 7:1
// R24: release bit writes ignored while stretch enable is zero, except in transmit
`timescale 1ns/1ps
`default_nettype none
`include "i2se_defines.vh"
module i2se_slave_engine (
  // Clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  // Bus pins
  input  wire       sclIn,
  output wire       sclOut,
  output wire       sclOe,
  input  wire       sdaIn,
  output wire       sdaOut,
  output wire       sdaOe,
  // Configuration
  input  wire [9:0] slaveAddress,
  input  wire       tenBitAddressSelect,
  input  wire       stretchEnable,
  // Transmit holding register
  input  wire       txWrite,
  input  wire [7:0] txData,
  // Receive buffer
  input  wire       rxRead,
  output wire [7:0] rxData,
  // Status and control
  input  wire       releaseSet,
  input  wire       collisionClear,
  input  wire       overflowClear,
  output wire       transmitBufferFull,
  output wire       writeCollisionFlag,
  output wire       receiveBufferFull,
  output wire       receiveOverflowFlag,
  output wire       tenBitMatchFlag,
  output wire       readDirection,
  output wire       dataNotAddress,
  output wire       clockReleaseBit,
  output wire       transferInterruptPulse
);

  // Reset release
  reg        rstS1_r;
  reg        rstS2_r;
  wire       rstN;
  // Pin synchronisers
  reg  [1:0] sclSync_r;
  reg  [1:0] sdaSync_r;
  reg        sclPrev_r;
  reg        sdaPrev_r;
  // Engine state
  reg  [2:0] state_r;
  reg  [3:0] bitCnt_r;
  reg  [7:0] rxShift_r;
  reg  [7:0] txShift_r;
  reg  [7:0] rxBuf_r;
  reg        tbf_r;
  reg        write_collision_flag_r;
  reg        rbf_r;
  reg        ov_r;
  reg        ten_bit_match_flag_r;
  reg        rw_r;
  reg        da_r;
  reg        rel_r;
  reg        sdaLow_r;
  reg        ackPend_r;
  reg        inTx_r;
  reg        txAckLow_r;
  reg        irq_r;
  reg        tenPrior_r;
  reg        firstTx_r;

  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;
  wire [7:0] byteIn;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstS1_r <= 1'b0;
      rstS2_r <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstS2_r <= rstS1_r;
    end
  end
  assign rstN = rstS2_r;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      sclPrev_r <= sclSync_r[1];
      sdaPrev_r <= sdaSync_r[1];
    end
  end

  assign sclRise   = sclSync_r[1] & ~sclPrev_r;
  assign sclFall   = ~sclSync_r[1] & sclPrev_r;
  assign startSeen = sclSync_r[1] & sclPrev_r & sdaPrev_r & ~sdaSync_r[1];
  assign stopSeen  = sclSync_r[1] & sclPrev_r & ~sdaPrev_r & sdaSync_r[1];
  // Byte as it will stand after the rising edge of bit 8
  assign byteIn    = {rxShift_r[6:0], sdaSync_r[1]};

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_r    <= `I2SE_ST_IDLE;
      bitCnt_r   <= 4'h0;
      rxShift_r  <= 8'h00;
      txShift_r  <= 8'h00;
      rxBuf_r    <= 8'h00;
      tbf_r      <= 1'b0;
      write_collision_flag_r    <= 1'b0;
      rbf_r      <= 1'b0;
      ov_r       <= 1'b0;
      ten_bit_match_flag_r    <= 1'b0;
      rw_r       <= 1'b0;
      da_r       <= 1'b0;
      rel_r      <= 1'b1;
      sdaLow_r   <= 1'b0;
      ackPend_r  <= 1'b0;
      inTx_r     <= 1'b0;
      txAckLow_r <= 1'b0;
      irq_r      <= 1'b0;
      tenPrior_r <= 1'b0;
      firstTx_r  <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      // R7: collision on write while full; set beats clear
      if (txWrite && tbf_r)
        write_collision_flag_r <= 1'b1;
      else if (collisionClear)
        write_collision_flag_r <= 1'b0;
      // R6: full flag set by CPU write
      if (txWrite && !tbf_r) begin
        tbf_r     <= 1'b1;
        txShift_r <= txData;
      end
      // R13: buffer read clears full flag
      if (rxRead)
        rbf_r <= 1'b0;
      if (overflowClear)
        ov_r <= 1'b0;
      // R24: release writes only honoured with stretch enabled or in transmit
      // R20: release settable whatever the buffer state
      if (releaseSet && (stretchEnable || inTx_r))
        rel_r <= 1'b1;

      if (stopSeen) begin
        state_r    <= `I2SE_ST_IDLE;
        sdaLow_r   <= 1'b0;
        inTx_r     <= 1'b0;
        tenPrior_r <= 1'b0;
        firstTx_r  <= 1'b0;
      end else if (startSeen) begin
        state_r   <= `I2SE_ST_ADDR;
        bitCnt_r  <= 4'h0;
        sdaLow_r  <= 1'b0;
        inTx_r    <= 1'b0;
        firstTx_r <= 1'b0;
      end else if (state_r != `I2SE_ST_IDLE) begin
        if (sclRise) begin
          if (bitCnt_r < `I2SE_BIT_COUNT) begin
            // R9: sample on rising edge
            rxShift_r <= byteIn;
            bitCnt_r  <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'h7 && !inTx_r) begin
              case (state_r)
                `I2SE_ST_ADDR: begin
                  // R16: ten-bit first byte; R23: seven-bit compare
                  if (tenBitAddressSelect) begin
                    if (byteIn[7:3] == `I2SE_TEN_BIT_PREFIX &&
                        byteIn[2:1] == slaveAddress[9:8] &&
                        (!byteIn[0] || (tenPrior_r && ten_bit_match_flag_r)))
                      ackPend_r <= 1'b1;
                    else begin
                      ten_bit_match_flag_r <= 1'b0;
                      state_r <= `I2SE_ST_IDLE;
                    end
                  end else if (byteIn[7:1] == slaveAddress[6:0])
                    ackPend_r <= 1'b1;
                  else
                    state_r <= `I2SE_ST_IDLE;
                end
                `I2SE_ST_ADDR10: begin
                  // R17: low eight bits
                  if (byteIn == slaveAddress[7:0])
                    ackPend_r <= 1'b1;
                  else begin
                    ten_bit_match_flag_r <= 1'b0;
                    state_r <= `I2SE_ST_IDLE;
                  end
                end
                `I2SE_ST_RX: begin
                  // R14: overflow on byte into full buffer
                  if (rbf_r)
                    ov_r <= 1'b1;
                  // R10 R12: load when buffer empty
                  if (!rbf_r) begin
                    rxBuf_r <= byteIn;
                    rbf_r   <= 1'b1;
                    // R15: last byte is data
                    da_r    <= 1'b1;
                  end
                  // R11 R12: ack only when empty and no overflow
                  ackPend_r <= !rbf_r && !ov_r;
                end
                default: ;
              endcase
            end
          end else begin
            // R4: ninth clock latches master ack
            if (inTx_r)
              txAckLow_r <= ~sdaSync_r[1];
          end
        end else if (sclFall) begin
          if (bitCnt_r == `I2SE_BIT_COUNT) begin
            // Drive ack slot
            sdaLow_r <= ackPend_r;
            if (inTx_r) begin
              sdaLow_r <= 1'b0;
              // R6: empty after 8 bits shifted
              tbf_r <= 1'b0;
            end
            bitCnt_r <= `I2SE_ACK_SLOT;
          end else if (bitCnt_r == `I2SE_ACK_SLOT) begin
            // Ninth falling edge
            sdaLow_r  <= 1'b0;
            bitCnt_r  <= 4'h0;
            ackPend_r <= 1'b0;
            if (inTx_r) begin
              // R3: pulse regardless of ack
              irq_r <= 1'b1;
              if (!txAckLow_r) begin
                // R4: nack ends transmit
                inTx_r  <= 1'b0;
                state_r <= `I2SE_ST_IDLE;
              end else if (!(tbf_r || (txWrite && !tbf_r))) begin
                // R5 R19: empty buffer, stretch
                rel_r <= 1'b0;
              end else begin
                // R2: first bit of next byte
                sdaLow_r <= ~txShift_r[7];
                txShift_r <= {txShift_r[6:0], 1'b1};
              end
            end else if (ackPend_r) begin
              irq_r <= 1'b1;
              case (state_r)
                `I2SE_ST_ADDR: begin
                  // R8: direction of last match
                  rw_r <= rxShift_r[0];
                  da_r <= 1'b0;
                  if (rxShift_r[0]) begin
                    // R1 R18: read match, stretch until transmit loaded
                    inTx_r  <= 1'b1;
                    state_r <= `I2SE_ST_TX;
                    if (tbf_r) begin
                      sdaLow_r  <= ~txShift_r[7];
                      txShift_r <= {txShift_r[6:0], 1'b1};
                    end else begin
                      rel_r     <= 1'b0;
                      firstTx_r <= 1'b1;
                    end
                  end else if (tenBitAddressSelect) begin
                    // R16: partial match clears flag
                    ten_bit_match_flag_r <= 1'b0;
                    state_r <= `I2SE_ST_ADDR10;
                  end else
                    state_r <= `I2SE_ST_RX;
                end
                `I2SE_ST_ADDR10: begin
                  ten_bit_match_flag_r    <= 1'b1;
                  tenPrior_r <= 1'b1;
                  state_r    <= `I2SE_ST_RX;
                end
                default: begin
                  // R21 R22: stretch when buffer still full
                  if (stretchEnable && rbf_r && !rxRead)
                    rel_r <= 1'b0;
                end
              endcase
            end else if (state_r == `I2SE_ST_RX) begin
              // R11: nacked byte still interrupts
              irq_r <= 1'b1;
              if (stretchEnable && rbf_r && !rxRead)
                rel_r <= 1'b0;
            end
          end else if (inTx_r && bitCnt_r != 4'h0) begin
            // R2: change data on falling edges
            sdaLow_r  <= ~txShift_r[7];
            txShift_r <= {txShift_r[6:0], 1'b1};
          end
        end
        if (inTx_r && !rel_r && bitCnt_r == 4'h0) begin
          // R1: after address, the transmit write releases the clock
          if (firstTx_r && txWrite && !tbf_r) begin
            rel_r     <= 1'b1;
            firstTx_r <= 1'b0;
            sdaLow_r  <= ~txData[7];
            txShift_r <= {txData[6:0], 1'b1};
          end else if (!firstTx_r && releaseSet && tbf_r) begin
            // R5: later bytes wait for the release bit
            rel_r     <= 1'b1;
            sdaLow_r  <= ~txShift_r[7];
            txShift_r <= {txShift_r[6:0], 1'b1};
          end
        end
      end
    end
  end

  // Open-drain drive: enable means pull low
  assign sclOut = 1'b0;
  assign sclOe  = ~rel_r;
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaLow_r;

  assign rxData                 = rxBuf_r;
  assign transmitBufferFull     = tbf_r;
  assign writeCollisionFlag     = write_collision_flag_r;
  assign receiveBufferFull      = rbf_r;
  assign receiveOverflowFlag    = ov_r;
  assign tenBitMatchFlag        = ten_bit_match_flag_r;
  assign readDirection          = rw_r;
  assign dataNotAddress         = da_r;
  assign clockReleaseBit        = rel_r;
  assign transferInterruptPulse = irq_r;

endmodule // i2se_slave_engine
`default_nettype wire

//--- core/i2se_defines.vh
// Constants for the two-wire slave engine.
// Included by the engine; holds definitions only.
`ifndef I2SE_DEFINES_VH
`define I2SE_DEFINES_VH
`define I2SE_TEN_BIT_PREFIX 5'h1e
`define I2SE_BIT_COUNT      4'h8
`define I2SE_ACK_SLOT       4'h9
`define I2SE_ADDR_RESET     10'h000
`define I2SE_ST_IDLE        3'h0
`define I2SE_ST_ADDR        3'h1
`define I2SE_ST_ADDR10      3'h2
`define I2SE_ST_RX          3'h3
`define I2SE_ST_TX          3'h4
`endif

//--- tb/i2se_engine_monitor.sv
// Port checker for the two-wire slave engine.
// Bound to every engine instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module i2se_engine_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  // CPU side
  input wire logic stretchEnable,
  input wire logic txWrite,
  input wire logic collisionClear,
  input wire logic overflowClear,
  input wire logic transmitBufferFull,
  input wire logic writeCollisionFlag,
  input wire logic receiveOverflowFlag,
  input wire logic readDirection,
  input wire logic clockReleaseBit,
  input wire logic transferInterruptPulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence sPulse;
    $rose(transferInterruptPulse);
  endsequence
  sequence sColWrite;
    txWrite && transmitBufferFull;
  endsequence
  AST_IRQ_ONE: assert property (sPulse |=> !transferInterruptPulse)
    else $error("interrupt pulse longer than one cycle");
  AST_SCL_HOLD: assert property (sclOe == !clockReleaseBit)
    else $error("clock drive differs from release bit");
  AST_COL_SET: assert property (sColWrite |=> writeCollisionFlag)
    else $error("collision flag not set");
  AST_COL_KEEP: assert property
    (writeCollisionFlag && !collisionClear |=> writeCollisionFlag)
    else $error("collision flag dropped");
  AST_TBF_SET: assert property
    (txWrite && !transmitBufferFull |=> transmitBufferFull)
    else $error("transmit full not set");
  AST_OVF_KEEP: assert property
    (receiveOverflowFlag && !overflowClear |=> receiveOverflowFlag)
    else $error("overflow flag dropped");
  AST_REL_KEEP: assert property
    (!stretchEnable && clockReleaseBit && !readDirection
     |=> clockReleaseBit || readDirection)
    else $error("release cleared with stretching off");
  AST_SDA_LOW: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line moved while clock high");
endmodule // i2se_engine_monitor
bind i2se_slave_engine i2se_engine_monitor mon (
  .core_clk, .nrst, .sclIn, .sclOe, .sdaOe, .stretchEnable, .txWrite,
  .collisionClear, .overflowClear, .transmitBufferFull,
  .writeCollisionFlag, .receiveOverflowFlag, .readDirection,
  .clockReleaseBit, .transferInterruptPulse
);
`default_nettype wire

//--- tb/i2se_bus_master.sv
// Behavioural master for the two-wire slave engine bench.
// Assumes pulled-up lines formed by the bench; 125 ns bit time.
`timescale 1ns/1ps
`default_nettype none
module i2se_bus_master (
  // Line levels
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Open-drain pull-downs
  output var logic  sclLow,
  output var logic  sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // Let clock go, bounded wait while the slave stretches
  task rise;
    sclLow = 1'b0;
    repeat (3000) if (!sclLine) #10;
  endtask
  task start;
    sdaLow = 1'b0;
    #62 rise;
    #31 sdaLow = 1'b1;
    #31 sclLow = 1'b1;
  endtask
  task bitOut(input logic b);
    #10 sdaLow = !b;
    #52 rise;
    #63 sclLow = 1'b1;
  endtask
  task bitIn(output logic b);
    #10 sdaLow = 1'b0;
    #52 rise;
    #62 b = sdaLine;
    #1 sclLow = 1'b1;
  endtask
  task byteOut(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(ack);
    #100;
  endtask
  task byteIn(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(ack);
    #100;
  endtask
  task stop;
    #10 sdaLow = 1'b1;
    #52 rise;
    #31 sdaLow = 1'b0;
  endtask
endmodule // i2se_bus_master
`default_nettype wire

//--- tb/test_i2se_slave_engine.sv
// Self-checking bench for the two-wire slave engine.
// Assumes a behavioural master on pulled-up bus lines.
`timescale 1ns/1ps
`default_nettype none
module test_i2se_slave_engine;
  localparam logic [4:0] TXW = 5'h10, RXR = 5'h08, REL = 5'h04;
  localparam logic [4:0] CCL = 5'h02, OCL = 5'h01;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [9:0] slaveAddress = 10'h05a;
  logic       tenBitAddressSelect = 1'b0;
  logic       stretchEnable = 1'b0;
  logic [4:0] strb = 5'h00;
  logic [7:0] txData = 8'h00;
  logic [7:0] rd;
  logic       ack;
  int         error_cnt = 0, compares = 0, cyc = 0;
  wire        txWrite, rxRead, releaseSet, collisionClear, overflowClear;
  wire [7:0]  rxData;
  wire        sclOe, sdaOe, mScl, mSda, transmit_buffer_full, wcol, receive_buffer_full, ovf;
  wire        tenM, rdDir, dna, rel, irq;
  wire        sclLine = !(sclOe || mScl);
  wire        sdaLine = !(sdaOe || mSda);
  assign {txWrite, rxRead, releaseSet, collisionClear, overflowClear} = strb;
  i2se_slave_engine uut (
    .core_clk, .nrst, .sclIn(sclLine), .sclOut(), .sclOe,
    .sdaIn(sdaLine), .sdaOut(), .sdaOe, .slaveAddress, .tenBitAddressSelect,
    .stretchEnable, .txWrite, .txData, .rxRead, .rxData, .releaseSet,
    .collisionClear, .overflowClear, .transmitBufferFull(transmit_buffer_full),
    .writeCollisionFlag(wcol), .receiveBufferFull(receive_buffer_full),
    .receiveOverflowFlag(ovf), .tenBitMatchFlag(tenM), .readDirection(rdDir),
    .dataNotAddress(dna), .clockReleaseBit(rel), .transferInterruptPulse(irq)
  );
  i2se_bus_master mst (
    .sclLine, .sdaLine, .sclLow(mScl), .sdaLow(mSda)
  );
  always #5 core_clk = !core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle CPU strobes, then let the bus react
  task cpu(input logic [4:0] s, input logic [7:0] d);
    @(posedge core_clk) #1;
    strb = s;
    txData = d;
    @(posedge core_clk) #1;
    strb = 5'h00;
    #200;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    chk("idle", 8'h01, {transmit_buffer_full, wcol, receive_buffer_full, ovf, tenM, rdDir, dna, rel});
    chk("rxData", 8'h00, rxData);
    mst.start;
    mst.byteOut(8'h36, ack);
    chk("foreign ack", 8'h01, ack);
    mst.stop;
    mst.start;
    mst.byteOut(8'hb4, ack);
    chk("addr ack", 8'h00, ack);
    chk("rbf dna dir", 8'h00, {receive_buffer_full, dna, rdDir});
    cpu(RXR, 8'h00);
    chk("rbf read", 8'h00, receive_buffer_full);
    mst.byteOut(8'ha5, ack);
    chk("data ack", 8'h00, {ack, ovf});
    chk("rx", 8'ha5, rxData);
    chk("dna", 8'h01, dna);
    mst.byteOut(8'h5c, ack);
    chk("full nack", 8'h03, {ack, ovf});
    chk("rx kept", 8'ha5, rxData);
    cpu(RXR, 8'h00);
    mst.byteOut(8'h3c, ack);
    chk("ovf nack", 8'h01, ack);
    chk("rx ovf", 8'h3c, rxData);
    mst.stop;
    cpu(RXR | OCL, 8'h00);
    @(posedge core_clk) #1 stretchEnable = 1'b1;
    mst.start;
    mst.byteOut(8'hb4, ack);
    chk("addr stretch", 8'h01, rel);
    cpu(RXR | REL, 8'h00);
    mst.byteOut(8'h81, ack);
    chk("data stretch", 8'h00, {ack, rel});
    chk("rx", 8'h81, rxData);
    cpu(RXR | REL, 8'h00);
    fork
      mst.byteOut(8'h42, ack);
      #1070 cpu(RXR, 8'h00);
    join
    chk("early read", 8'h01, rel);
    chk("rx", 8'h42, rxData);
    mst.stop;
    @(posedge core_clk) #1 stretchEnable = 1'b0;
    mst.start;
    mst.byteOut(8'hb5, ack);
    chk("read hold", 8'h01, {ack, rel, rdDir});
    cpu(TXW | RXR, 8'hc3);
    cpu(TXW, 8'h11);
    chk("collide", 8'h03, {transmit_buffer_full, wcol});
    cpu(CCL, 8'h00);
    chk("collide clr", 8'h00, wcol);
    mst.byteIn(rd, 1'b0);
    chk("tx", 8'hc3, rd);
    chk("tx empty", 8'h00, {transmit_buffer_full, rel});
    cpu(TXW, 8'h5e);
    chk("tx wait", 8'h00, rel);
    cpu(REL, 8'h00);
    mst.byteIn(rd, 1'b1);
    chk("tx2", 8'h5e, rd);
    chk("nack end", 8'h01, rel);
    mst.stop;
    @(posedge core_clk) #1 tenBitAddressSelect = 1'b1;
    slaveAddress = 10'h2b7;
    mst.start;
    mst.byteOut(8'hf4, ack);
    chk("ten hi", 8'h00, {ack, tenM});
    cpu(RXR, 8'h00);
    mst.byteOut(8'hb7, ack);
    chk("ten lo", 8'h01, {ack, tenM});
    cpu(RXR, 8'h00);
    mst.start;
    mst.byteOut(8'hf5, ack);
    chk("ten read", 8'h01, {ack, rel, rdDir});
    cpu(TXW | RXR, 8'h96);
    mst.byteIn(rd, 1'b1);
    chk("ten tx", 8'h96, rd);
    mst.stop;
    mst.start;
    mst.byteOut(8'hf5, ack);
    chk("ten dir one", 8'h02, {ack, tenM});
    mst.stop;
    end_of_test;
  end
endmodule // test_i2se_slave_engine
`default_nettype wire
